/* rtl/t2cu_pkg.sv */
// package for the timer 2 control unit: register map, fields, timing
// assumes a byte-wide special-function-register bus on the system clock
`default_nettype none
package t2cu_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'hc8; // control register address
   localparam logic [7:0] CTRL_RESET = 8'h00; // control reset value
   // ----------------------------------------
   // field positions in the control register
   // ----------------------------------------
   localparam int HI_OVF_BIT = 7; // high overflow flag
   localparam int LO_OVF_BIT = 6; // low overflow flag
   localparam int LO_IRQ_EN_BIT = 5; // low-byte interrupt enable
   localparam int CAP_EN_BIT = 4; // capture enable
   localparam int SPLIT_BIT = 3; // split select
   localparam int RUN_BIT = 2; // run control
   localparam int ALT_CLK_HI_BIT = 1; // alt clock select, upper bit
   // ----------------------------------------
   // clock and trigger choices
   // ----------------------------------------
   localparam logic [1:0] ALT_SEL_RTC = 2'h3; // alt clock is osc/8
   localparam logic [3:0] DIV12_LAST = 4'hb; // divide by 12 terminal
   localparam logic [2:0] DIV8_LAST = 3'h7; // divide by 8 terminal
   localparam logic [7:0] BYTE_ONES = 8'hff; // byte all ones
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] addr; // register address
      logic [7:0] wdata; // write data
      logic wr; // byte write strobe
      logic bit_op; // single-bit write
      logic [2:0] bit_idx; // bit position for single-bit write
   } t2cu_bus_type;
endpackage
`default_nettype wire

/* rtl/t2cu_top.sv */
// timer 2 control unit: control register, counter, reload, capture
// assumes one system clock; oscillator and comparator arrive asynchronously
`default_nettype none
module t2cu_top
(
   input wire logic clock, // system clock
   input wire logic rst_b, // async reset, active low
   input wire t2cu_pkg::t2cu_bus_type bus_in, // register bus request
   input wire logic [7:0] count_low_wr, // low counter write data
   input wire logic count_low_we, // low counter write strobe
   input wire logic [7:0] count_high_wr, // high counter write data
   input wire logic count_high_we, // high counter write strobe
   input wire logic [7:0] reload_low_wr, // low reload write data
   input wire logic reload_low_we, // low reload write strobe
   input wire logic [7:0] reload_high_wr, // high reload write data
   input wire logic reload_high_we, // high reload write strobe
   input wire logic high_byte_clock_pick, // high byte uses system clock in split mode
   input wire logic low_byte_clock_pick, // low byte uses system clock
   input wire logic timer_irq_enable, // timer interrupt enabled
   input wire logic rtc_osc, // low-frequency oscillator, async
   input wire logic cmp0_out, // comparator 0 output, async
   output logic [7:0] timer_control_reg, // control register read value
   output logic [15:0] count_value, // counter read value
   output logic [15:0] reload_value, // reload read value
   output logic irq_req // interrupt request level
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] ctrl_ff; // control register
   logic [7:0] cnt_lo_ff; // counter low byte
   logic [7:0] cnt_hi_ff; // counter high byte
   logic [7:0] rld_lo_ff; // reload low byte
   logic [7:0] rld_hi_ff; // reload high byte
   logic [3:0] div12_ff; // system clock divider
   logic [2:0] rtc_sync_ff; // oscillator sync and edge stages
   logic [2:0] cmp_sync_ff; // comparator sync and edge stages
   logic [2:0] rtc_div_ff; // oscillator divide by 8
   // ----------------------------------------
   // synchronisers and event strobes
   // ----------------------------------------
   // first stage read only by the second
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rtc_sync_ff <= 3'h0;
         cmp_sync_ff <= 3'h0;
      end
      else
      begin
         rtc_sync_ff <= {rtc_sync_ff[1:0], rtc_osc};
         cmp_sync_ff <= {cmp_sync_ff[1:0], cmp0_out};
      end
   end
   logic rtc_rise; // synchronised oscillator rising edge
   logic cmp_rise; // synchronised comparator rising edge
   logic rtc_tick; // every 8 oscillator cycles
   logic div12_tick; // every 12 system clocks
   assign rtc_rise = rtc_sync_ff[1] & ~rtc_sync_ff[2];
   assign cmp_rise = cmp_sync_ff[1] & ~cmp_sync_ff[2];
   assign rtc_tick = rtc_rise && rtc_div_ff == t2cu_pkg::DIV8_LAST;
   assign div12_tick = div12_ff == t2cu_pkg::DIV12_LAST;
   // dividers for the alternate sources
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div12_ff <= 4'h0;
         rtc_div_ff <= 3'h0;
      end
      else
      begin
         div12_ff <= div12_tick ? 4'h0 : div12_ff + 4'h1;
         if (rtc_rise)
            rtc_div_ff <= rtc_div_ff + 3'h1;
      end
   end
   // ----------------------------------------
   // clock selection and counting
   // ----------------------------------------
   logic [1:0] alt_clock_select; // alternate clock select field
   logic split_select; // split mode
   logic run_control; // run control
   logic capture_enable; // capture mode
   logic alt_tick; // alternate clock event
   logic cap_evt; // capture event
   logic tick_lo; // low byte advance
   logic tick_hi_split; // high byte advance in split mode
   logic lo_wrap; // low byte rolls over
   logic hi_wrap; // high byte rolls over
   assign alt_clock_select = ctrl_ff[t2cu_pkg::ALT_CLK_HI_BIT -: 2];
   assign split_select = ctrl_ff[t2cu_pkg::SPLIT_BIT];
   assign run_control = ctrl_ff[t2cu_pkg::RUN_BIT];
   assign capture_enable = ctrl_ff[t2cu_pkg::CAP_EN_BIT];
   // code 11 picks osc/8, others system clock /12
   assign alt_tick = (alt_clock_select == t2cu_pkg::ALT_SEL_RTC) ?
                     rtc_tick : div12_tick;
   // trigger by upper select bit
   assign cap_evt = capture_enable &&
                    (alt_clock_select[1] ? cmp_rise : rtc_tick);
   // low byte picks alt or system clock; high byte does in split mode, else counts low carries
   // low byte free-runs in split mode else gated
   assign tick_lo = (low_byte_clock_pick | alt_tick) &&
                    (split_select || run_control);
   assign tick_hi_split = (high_byte_clock_pick | alt_tick) && run_control;
   assign lo_wrap = tick_lo && cnt_lo_ff == t2cu_pkg::BYTE_ONES;
   // split or 16-bit carry
   assign hi_wrap = cnt_hi_ff == t2cu_pkg::BYTE_ONES &&
                    (split_select ? tick_hi_split : lo_wrap);
   // counter bytes with auto-reload
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_lo_ff <= 8'h00;
         cnt_hi_ff <= 8'h00;
      end
      else
      begin
         if (count_low_we)
            cnt_lo_ff <= count_low_wr;
         else if (lo_wrap)
            cnt_lo_ff <= split_select ? rld_lo_ff :
                         (hi_wrap ? rld_lo_ff : 8'h00);
         else if (tick_lo)
            cnt_lo_ff <= cnt_lo_ff + 8'h01;
         if (count_high_we)
            cnt_hi_ff <= count_high_wr;
         else if (hi_wrap)
            cnt_hi_ff <= rld_hi_ff;
         else if (split_select ? tick_hi_split : lo_wrap)
            cnt_hi_ff <= cnt_hi_ff + 8'h01;
      end
   end
   // reload registers, loaded by capture
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rld_lo_ff <= 8'h00;
         rld_hi_ff <= 8'h00;
      end
      else if (cap_evt)
      begin
         rld_lo_ff <= cnt_lo_ff;
         rld_hi_ff <= cnt_hi_ff;
      end
      else
      begin
         if (reload_low_we)
            rld_lo_ff <= reload_low_wr;
         if (reload_high_we)
            rld_hi_ff <= reload_high_wr;
      end
   end
   // ----------------------------------------
   // control register
   // ----------------------------------------
   logic ctrl_hit; // write aimed at the control register
   logic [7:0] sw_val; // value after the software write
   logic [7:0] nxt_ctrl; // next control value
   assign ctrl_hit = bus_in.wr && bus_in.addr == t2cu_pkg::CTRL_ADDR;
   // fixed address, byte or single-bit write
   always_comb
   begin
      sw_val = ctrl_ff;
      if (ctrl_hit && bus_in.bit_op)
         sw_val[bus_in.bit_idx] = bus_in.wdata[0];
      else if (ctrl_hit)
         sw_val = bus_in.wdata;
      nxt_ctrl = sw_val;
      // hardware set wins over clear never self-clear
      if (hi_wrap || cap_evt)
         nxt_ctrl[t2cu_pkg::HI_OVF_BIT] = 1'b1;
      if (lo_wrap)
         nxt_ctrl[t2cu_pkg::LO_OVF_BIT] = 1'b1;
   end
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         ctrl_ff <= t2cu_pkg::CTRL_RESET;
      else
         ctrl_ff <= nxt_ctrl;
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign timer_control_reg = ctrl_ff;
   assign count_value = {cnt_hi_ff, cnt_lo_ff};
   assign reload_value = {rld_hi_ff, rld_lo_ff};
   // with timer_irq_enable: high flag always, low flag when low enable set
   assign irq_req = timer_irq_enable &&
                    (ctrl_ff[t2cu_pkg::HI_OVF_BIT] ||
                     (ctrl_ff[t2cu_pkg::LO_IRQ_EN_BIT] &&
                      ctrl_ff[t2cu_pkg::LO_OVF_BIT]));
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic hi_flag; // stored high overflow flag
   logic lo_flag; // stored low overflow flag
   logic lo_irq_en; // stored low-byte interrupt enable
   assign hi_flag = ctrl_ff[t2cu_pkg::HI_OVF_BIT];
   assign lo_flag = ctrl_ff[t2cu_pkg::LO_OVF_BIT];
   assign lo_irq_en = ctrl_ff[t2cu_pkg::LO_IRQ_EN_BIT];
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   hi_flag_set_a: assert property (hi_wrap |=> hi_flag)
      else $error("high flag not set on wrap");
   lo_flag_set_a: assert property (lo_wrap |=> lo_flag)
      else $error("low flag not set on wrap");
   flag_hold_a: assert property ($fell(hi_flag) |->
      $past(ctrl_hit))
      else $error("high flag cleared without write");
   lo_hold_a: assert property ($fell(lo_flag) |->
      $past(ctrl_hit))
      else $error("low flag cleared without write");
   irq_hi_a: assert property (timer_irq_enable && hi_flag |->
      irq_req)
      else $error("missing high interrupt");
   irq_lo_a: assert property (timer_irq_enable && lo_irq_en &&
      lo_flag |-> irq_req)
      else $error("missing low interrupt");
   halt_hold_a: assert property (!split_select && !run_control &&
      !count_low_we && !count_high_we |=> $stable(count_value))
      else $error("counter moved while halted");
   reload_16_a: assert property (hi_wrap && !split_select &&
      !count_low_we && !count_high_we |=>
      count_value == $past(reload_value))
      else $error("no reload on wrap");
   capture_a: assert property (cap_evt |=>
      reload_value == $past(count_value) && hi_flag)
      else $error("capture did not copy counter");
   set_wins_a: assert property (lo_wrap && ctrl_hit |=> lo_flag)
      else $error("clear beat hardware set");
endmodule
`default_nettype wire

/* sim/t2cu_top_tb.sv */
// testbench for the timer 2 control unit: register, counter, capture
// assumes the design package is compiled first; one 40 MHz clock
`default_nettype none
module t2cu_top_tb;
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// signals and scoreboard
// ----------------------------------------
typedef struct {string name; int which; logic [15:0] exp;} t2cu_note_type;
t2cu_note_type q[$]; // expected results, oldest first
event chk; // a result is ready to compare
int n_errors = 0;
int num_checks = 0;
logic clock = 1'b0;
logic rst_b = 1'b0; // active low reset
t2cu_pkg::t2cu_bus_type bus_in = '0;
logic [7:0] cl_wr = '0, ch_wr = '0, rl_wr = '0, rh_wr = '0;
logic cl_we = 1'b0, ch_we = 1'b0, rl_we = 1'b0, rh_we = 1'b0;
logic pick_hi = 1'b0, pick_lo = 1'b0, irq_en = 1'b0;
logic rtc = 1'b0, cmp = 1'b0;
logic [7:0] ctrl;
logic [15:0] cnt, rld, rl, c0, delta;
logic irq;
int code;
always #12.5 clock = ~clock; // 25 ns period
t2cu_top DUT (.clock(clock), .rst_b(rst_b), .bus_in(bus_in),
   .count_low_wr(cl_wr), .count_low_we(cl_we), .count_high_wr(ch_wr),
   .count_high_we(ch_we), .reload_low_wr(rl_wr), .reload_low_we(rl_we),
   .reload_high_wr(rh_wr), .reload_high_we(rh_we),
   .high_byte_clock_pick(pick_hi), .low_byte_clock_pick(pick_lo),
   .timer_irq_enable(irq_en), .rtc_osc(rtc), .cmp0_out(cmp),
   .timer_control_reg(ctrl), .count_value(cnt), .reload_value(rld),
   .irq_req(irq));
// ----------------------------------------
// tasks
// ----------------------------------------
// record one expectation and wake the monitor
task note(input string nm, input int w, input logic [15:0] e);
   q.push_back('{nm, w, e});
   -> chk;
endtask
// wait n rising edges, then the falling edge where outputs are settled
task step(input int n);
   repeat (n) @(posedge clock);
   @(negedge clock);
endtask
// one register bus write, strobe held for one edge
task wr(input logic [7:0] a, input logic [7:0] d, input int b,
   input int i);
   @(negedge clock);
   bus_in = '{a, d, 1'b1, b[0], i[2:0]};
   @(negedge clock);
   bus_in.wr = 1'b0;
endtask
// direct counter write, both bytes at once
task cw(input logic [15:0] v);
   @(negedge clock);
   {ch_wr, cl_wr} = v;
   {ch_we, cl_we} = 2'b11;
   @(negedge clock);
   {ch_we, cl_we} = 2'b00;
endtask
// reload write, both bytes at once
task rw(input logic [15:0] v);
   @(negedge clock);
   {rh_wr, rl_wr} = v;
   {rh_we, rl_we} = 2'b11;
   @(negedge clock);
   {rh_we, rl_we} = 2'b00;
endtask
// slow oscillator, n rising edges of 16 cycles each
task osc(input int n);
   repeat (n)
   begin
      rtc = 1'b1;
      repeat (8) @(negedge clock);
      rtc = 1'b0;
      repeat (8) @(negedge clock);
   end
endtask
// bounded wait for a control bit to go high
task wait_bit(input int i);
   for (int k = 0; k < 3000 && ctrl[i] !== 1'b1; k++)
      step(1);
   if (ctrl[i] !== 1'b1)
   begin
      n_errors++;
      $display("ERROR bit %0d exp 1 got %b", i, ctrl[i]);
   end
endtask
// verdict and end of run; the pause lets the monitor drain the queue
task results();
   #1;
   $display("checks %0d errors %0d", num_checks, n_errors);
   if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
   else
      $display("STATUS NOT OK");
   $finish;
endtask
// ----------------------------------------
// monitor: compares oldest note with the outputs
// ----------------------------------------
always @(chk)
begin
   while (q.size() > 0)
   begin
      t2cu_note_type n;
      logic [15:0] got;
      n = q.pop_front();
      case (n.which)
         0: got = {8'h00, ctrl};
         1: got = cnt;
         2: got = rld;
         3: got = {15'h0000, irq};
         default: got = delta;
      endcase
      num_checks++;
      if (got !== n.exp)
      begin
         n_errors++;
         $display("ERROR %s exp %h got %h", n.name, n.exp, got);
      end
   end
end
// watchdog cuts a hang short
initial
begin
   #(25 * 20000);
   n_errors++;
   results();
end
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
   void'($urandom(81210));
   rl = 16'($urandom);
   repeat (20) @(negedge clock);
   rst_b = 1'b1;
   step(1);
   note("ctrl", 0, 16'h0000);
   note("irq", 3, 16'h0000);
   c0 = {8'h00, 8'($urandom) & 8'h3b}; // no flags, no run
   wr(8'hc8, c0[7:0], 0, 0);
   note("ctrl", 0, c0);
   wr(8'hc9, 8'hff, 0, 0); // unmapped address is ignored
   note("ctrl", 0, c0);
   wr(8'hc8, 8'h00, 0, 0);
   rw(rl);
   cw(16'hfffd);
   pick_lo = 1'b1;
   irq_en = 1'b1;
   wr(8'hc8, 8'h01, 1, 3'h2); // set run by single-bit op
   wait_bit(7);
   note("count", 1, rl);
   note("ctrl", 0, 16'h00c4);
   note("irq", 3, 16'h0001);
   wr(8'hc8, 8'h00, 1, 3'h2);
   c0 = cnt;
   step(20);
   delta = cnt - c0;
   note("ctrl", 0, 16'h00c0);
   note("halt", 4, 16'h0000);
   wr(8'hc8, 8'h00, 1, 3'h7);
   note("irq", 3, 16'h0000);
   wr(8'hc8, 8'h01, 1, 3'h5);
   note("irq", 3, 16'h0001);
   wr(8'hc8, 8'h00, 1, 3'h6);
   note("irq", 3, 16'h0000);
   cw(16'h55fd); // split mode, run off: only low byte moves
   wr(8'hc8, 8'h08, 0, 0);
   wait_bit(6);
   note("ctrl", 0, 16'h0048);
   note("count", 1, {8'h55, rl[7:0]});
   cw(16'h00fe); // low wraps in the very cycle of the clear below
   wr(8'hc8, 8'h00, 1, 3'h6);
   note("ctrl", 0, 16'h0048);
   c0 = 16'($urandom); // capture on comparator rise, counter frozen
   wr(8'hc8, 8'h12, 0, 0);
   cw(c0);
   cmp = 1'b1;
   wait_bit(7);
   note("capture", 2, c0);
   note("ctrl", 0, 16'h0092);
   cmp = 1'b0;
   wr(8'hc8, 8'h13, 0, 0); // select 11 also triggers on comparator
   c0 = 16'($urandom);
   cw(c0);
   cmp = 1'b1;
   wait_bit(7);
   note("capture", 2, c0);
   cmp = 1'b0;
   wr(8'hc8, 8'h10, 0, 0);
   c0 = {1'b0, 15'($urandom)}; // top bit clear: no wrap later
   cw(c0);
   osc(8);
   wait_bit(7);
   note("capture", 2, c0);
   pick_lo = 1'b0;
   for (code = 0; code < 3; code++)
   begin
      wr(8'hc8, 8'h04 | 8'(code), 0, 0);
      step(24);
      c0 = cnt;
      step(120);
      delta = cnt - c0;
      note("div12", 4, 16'h000a);
   end
   wr(8'hc8, 8'h07, 0, 0);
   step(4);
   c0 = cnt;
   osc(16);
   step(4);
   delta = cnt - c0;
   note("osc8", 4, 16'h0002);
   pick_hi = 1'b1; // split: high on system clock, low on alt
   wr(8'hc8, 8'h0c, 0, 0);
   cw(16'h0000);
   step(2);
   c0 = cnt;
   step(24);
   delta = cnt - c0;
   note("split", 4, 16'h1802);
   results();
end
endmodule
`default_nettype wire
